// ---- inc/mbf_consts.svh ----
// shared constants for the microcontroller bus front end
`ifndef MBF_CONSTS_SVH
`define MBF_CONSTS_SVH
`define MBF_BYTE_W 8
`define MBF_ADDR_W 16
`define MBF_SEL_W 4
`define MBF_MODE_MUX 2'h0
`define MBF_MODE_NONMUX 2'h1
`define MBF_MODE_PAGE 2'h2
`define MBF_MODE_BURST 2'h3
`define MBF_ZERO_BYTE 8'h00
`define MBF_ZERO_ADDR 16'h0000
`define MBF_HIDX 15
`define MBF_LIDX 8
`endif

// ---- inc/mbf_pkg.sv ----
// types for the microcontroller bus front end
package mbf_pkg;
  typedef enum logic [1:0] {
    MBF_WR_STROBE = 2'h0,
    MBF_WR_RNW = 2'h1
  } mbf_wr_style_t;
  typedef enum logic [1:0] {
    MBF_RD_STROBE = 2'h0,
    MBF_RD_ECLK = 2'h1,
    MBF_RD_DSTROBE = 2'h2,
    MBF_RD_PFETCH = 2'h3
  } mbf_rd_style_t;
  typedef enum logic [2:0] {
    MBF_H_IDLE = 3'h1,
    MBF_H_ADDR = 3'h2,
    MBF_H_DATA = 3'h4
  } mbf_hstate_t;
endpackage

// ---- inc/mbf_bus_if.sv ----
// pin-level bus between host and device
`timescale 1ns/1ps
interface mbf_bus_if;
  logic [7:0] lo_h2d;
  logic [7:0] lo_h_oe_n;
  logic [7:0] up_h2d;
  logic [7:0] up_h_oe_n;
  logic [7:0] lo_d2h;
  logic lo_d_oe_n;
  logic [7:0] up_d2h;
  logic up_d_oe_n;
  logic address_strobe;
  logic write_control_input;
  logic read_control_input;
  logic code_fetch_input;
  modport host (output lo_h2d, lo_h_oe_n, up_h2d, up_h_oe_n, address_strobe, write_control_input,
                read_control_input, code_fetch_input, input lo_d2h, lo_d_oe_n, up_d2h, up_d_oe_n);
  modport dev (input lo_h2d, lo_h_oe_n, up_h2d, up_h_oe_n, address_strobe, write_control_input,
               read_control_input, code_fetch_input, output lo_d2h, lo_d_oe_n, up_d2h, up_d_oe_n);
endinterface

// ---- rtl/mbf_sync.sv ----
// two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module mbf_sync #(
  parameter int W = 1
) (
  input wire logic MCLK_I,
  input wire logic RSTN_I,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1_r;
  initial begin
    if (W < 1) $error("mbf_sync: W must be positive");
  end
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      s1_r <= '0;
      q_o <= '0;
    end else begin
      s1_r <= d_i;
      q_o <= s1_r;
    end
  end
endmodule // mbf_sync

// ---- rtl/mbf_device.sv ----
// device end: address latch, control decode, read data drive
`timescale 1ns/1ps
`include "mbf_consts.svh"
module mbf_device
  import mbf_pkg::*;
#(
  parameter int SEL_W = `MBF_SEL_W
) (
  // clock and reset
  input wire logic MCLK_I,
  input wire logic RSTN_I,
  // pins
  mbf_bus_if.dev BUS,
  // configuration
  input wire logic [1:0] BUS_MODE_I,
  input wire logic [1:0] WR_STYLE_I,
  input wire logic [1:0] RD_STYLE_I,
  input wire logic AS_ACTIVE_HIGH_I,
  // decode and read data
  input wire logic [SEL_W-1:0] BLOCK_SEL_I,
  input wire logic [7:0] RD_LO_I,
  input wire logic [7:0] RD_UP_I,
  // towards the logic arrays
  output logic [15:0] ARRAY_ADDR_O,
  output logic ARRAY_WR_O,
  output logic ARRAY_RD_O,
  output logic ARRAY_FETCH_O,
  output logic [7:0] WDATA_LO_O,
  output logic [7:0] WDATA_UP_O,
  output logic WRITE_STB_O
);
  initial begin
    if (SEL_W < 1) $error("mbf_device: SEL_W must be positive");
  end
  typedef struct packed {
    logic [15:0] addr;
    logic as_d;
    logic wr_d;
    logic wr;
    logic rd;
    logic fetch;
    logic drive;
    logic [7:0] lo_o;
    logic [7:0] up_o;
    logic [7:0] wlo;
    logic [7:0] wup;
    logic wstb;
  } mbf_dev_st_t;
  mbf_dev_st_t st_r, st_nxt;
  logic [7:0] lo_s, up_s;
  logic as_s, wc_s, rc_s, cf_s;
  // all host pins are asynchronous to this clock
  mbf_sync #(.W(20)) u_sync (
    .MCLK_I(MCLK_I),
    .RSTN_I(RSTN_I),
    .d_i({BUS.lo_h2d, BUS.up_h2d, BUS.address_strobe, BUS.write_control_input,
          BUS.read_control_input, BUS.code_fetch_input}),
    .q_o({lo_s, up_s, as_s, wc_s, rc_s, cf_s})
  );
  // decodes the read qualifier for every supported host style
  function automatic logic rd_active(input logic [1:0] sty, input logic rc, input logic wc);
    unique case (sty)
      MBF_RD_ECLK: rd_active = rc & wc; // E high with direction = read
      default: rd_active = ~rc; // strobe, data strobe, program fetch all low
    endcase
  endfunction
  logic as_lvl, wr_lvl;
  always_comb begin
    st_nxt = st_r;
    as_lvl = AS_ACTIVE_HIGH_I ? as_s : ~as_s;
    // address is transparent while the strobe is active, held afterwards
    st_nxt.as_d = as_lvl;
    if (as_lvl) begin
      st_nxt.addr = {up_s, lo_s};
    end
    // r/w direction low means write; qualified by the data phase strobe
    if (WR_STYLE_I == MBF_WR_RNW) begin
      wr_lvl = ~wc_s & ~rc_s;
    end else begin
      wr_lvl = ~wc_s;
    end
    st_nxt.wr = wr_lvl & ~as_lvl;
    st_nxt.rd = rd_active(RD_STYLE_I, rc_s, wc_s) & ~as_lvl;
    st_nxt.fetch = ~cf_s;
    st_nxt.wr_d = st_nxt.wr;
    st_nxt.wstb = st_r.wr & ~st_nxt.wr;
    // capture only while the synchronised strobe is still low, so the address that
    // returns on the port as the strobe rises is never taken as data
    if (st_nxt.wr) begin
      st_nxt.wlo = lo_s;
      st_nxt.wup = (BUS_MODE_I == `MBF_MODE_PAGE || BUS_MODE_I == `MBF_MODE_BURST) ? up_s : `MBF_ZERO_BYTE;
    end
    // limitation: selection from the decode arrays is trusted as given
    st_nxt.drive = st_nxt.rd & (|BLOCK_SEL_I);
    st_nxt.lo_o = st_nxt.drive ? RD_LO_I : `MBF_ZERO_BYTE;
    st_nxt.up_o = (st_nxt.drive && (BUS_MODE_I == `MBF_MODE_PAGE || BUS_MODE_I == `MBF_MODE_BURST)) ?
                  RD_UP_I : `MBF_ZERO_BYTE;
  end
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign BUS.lo_d2h = st_r.lo_o;
  assign BUS.up_d2h = st_r.up_o;
  assign BUS.lo_d_oe_n = ~st_r.drive;
  assign BUS.up_d_oe_n = ~(st_r.drive & (st_r.up_o != `MBF_ZERO_BYTE || BUS_MODE_I[1]));
  assign ARRAY_ADDR_O = st_r.addr;
  assign ARRAY_WR_O = st_r.wr;
  assign ARRAY_RD_O = st_r.rd;
  assign ARRAY_FETCH_O = st_r.fetch;
  assign WDATA_LO_O = st_r.wlo;
  assign WDATA_UP_O = st_r.wup;
  assign WRITE_STB_O = st_r.wstb;
endmodule // mbf_device

// ---- rtl/mbf_host.sv ----
// host end: simple 8-bit microcontroller bus sequencer
`timescale 1ns/1ps
`include "mbf_consts.svh"
module mbf_host
  import mbf_pkg::*;
#(
  parameter int PHASE_CYC = 4
) (
  // clock and reset
  input wire logic MCLK_I,
  input wire logic RSTN_I,
  // pins
  mbf_bus_if.host BUS,
  // user side
  input wire logic REQ_I,
  input wire logic REQ_WR_I,
  input wire logic [15:0] REQ_ADDR_I,
  input wire logic [7:0] REQ_WDATA_I,
  input wire logic MUX_I,
  output logic BUSY_O,
  output logic DONE_O,
  output logic [7:0] RDATA_O
);
  initial begin
    if (PHASE_CYC < 2 || PHASE_CYC > 255) $error("mbf_host: PHASE_CYC out of range");
  end
  typedef struct packed {
    mbf_hstate_t st;
    logic [7:0] cnt;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wd;
    logic [7:0] rd;
    logic done;
    logic busy;
  } mbf_host_st_t;
  mbf_host_st_t s_r, s_nxt;
  logic [7:0] lo_s;
  // read data comes from the device pins
  mbf_sync #(.W(8)) u_sync (
    .MCLK_I(MCLK_I),
    .RSTN_I(RSTN_I),
    .d_i(BUS.lo_d2h),
    .q_o(lo_s)
  );
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    unique case (s_r.st)
      MBF_H_IDLE: begin
        if (REQ_I) begin
          s_nxt.st = MBF_H_ADDR;
          s_nxt.wr = REQ_WR_I;
          s_nxt.addr = REQ_ADDR_I;
          s_nxt.wd = REQ_WDATA_I;
          s_nxt.cnt = 8'(PHASE_CYC);
          s_nxt.busy = 1'b1;
        end
      end
      MBF_H_ADDR: begin
        s_nxt.cnt = s_r.cnt - 8'h01;
        if (s_r.cnt == 8'h01) begin
          s_nxt.st = MBF_H_DATA;
          s_nxt.cnt = 8'(PHASE_CYC) + 8'(2); // room for device pin synchronisers
        end
      end
      MBF_H_DATA: begin
        s_nxt.cnt = s_r.cnt - 8'h01;
        if (s_r.cnt == 8'h01) begin
          s_nxt.st = MBF_H_IDLE;
          s_nxt.done = 1'b1;
          s_nxt.busy = 1'b0;
          if (!s_r.wr) begin
            s_nxt.rd = lo_s;
          end
        end
      end
      default: s_nxt.st = MBF_H_IDLE;
    endcase
  end
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      s_r <= '{st: MBF_H_IDLE, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end
  logic in_addr, in_data;
  assign in_addr = (s_r.st == MBF_H_ADDR);
  assign in_data = (s_r.st == MBF_H_DATA);
  // low byte carries address, then write data or nothing, so a read never meets the device
  assign BUS.lo_h2d = (in_data && s_r.wr) ? s_r.wd : s_r.addr[7:0];
  assign BUS.lo_h_oe_n = {8{~(in_addr | (in_data & s_r.wr))}};
  assign BUS.up_h2d = s_r.addr[`MBF_HIDX:`MBF_LIDX];
  // a non-multiplexed host keeps the upper address through the data phase
  assign BUS.up_h_oe_n = {8{~(in_addr | (in_data & ~MUX_I))}};
  assign BUS.address_strobe = in_addr; // active high address latch
  assign BUS.write_control_input = ~(in_data & s_r.wr);
  assign BUS.read_control_input = ~(in_data & ~s_r.wr);
  assign BUS.code_fetch_input = 1'b1;
  assign BUSY_O = s_r.busy;
  assign DONE_O = s_r.done;
  assign RDATA_O = s_r.rd;
endmodule // mbf_host

// ---- bench/mbf_bus_monitor.sv ----
// assertion checker watching the pins between host and device
`timescale 1ns/1ps
module mbf_bus_monitor (
  // clock and reset
  input wire logic MCLK_I,
  input wire logic RSTN_I,
  // bus pins
  input wire logic [7:0] lo_h_oe_n,
  input wire logic lo_d_oe_n,
  input wire logic up_d_oe_n,
  input wire logic address_strobe,
  input wire logic write_control_input,
  input wire logic read_control_input
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RSTN_I);
  // device pins lag the strobes by the synchroniser and one register
  drive_cause_a: assert property ($fell(lo_d_oe_n) |-> !$past(read_control_input, 3))
    else $error("device drove without a read");
  drive_release_a: assert property ($rose(read_control_input) |-> ##[1:4] (lo_d_oe_n && up_d_oe_n))
    else $error("device kept driving after the read");
  write_quiet_a: assert property (!write_control_input |-> lo_d_oe_n && up_d_oe_n)
    else $error("device drove during a write");
  addr_quiet_a: assert property (address_strobe |-> lo_d_oe_n && up_d_oe_n)
    else $error("device drove during the address phase");
  no_clash_a: assert property (!lo_d_oe_n |-> &lo_h_oe_n)
    else $error("both ends drive the lower port");
  strobe_excl_a: assert property (!(!read_control_input && !write_control_input))
    else $error("read and write active together");
  phase_order_a: assert property ($fell(address_strobe) |-> ##[0:2] (!read_control_input || !write_control_input))
    else $error("no data phase after the address");
  drive_hold_a: assert property ($fell(lo_d_oe_n) |-> !lo_d_oe_n [*3])
    else $error("read data not held");
endmodule // mbf_bus_monitor

// ---- bench/mcu_bus_front_end_tb.sv ----
// self-checking bench joining host and device ends
`timescale 1ns/1ps
module mcu_bus_front_end_tb;
  import mbf_pkg::*;
  logic MCLK_I = 1'b0;
  logic RSTN_I = 1'b0;
  logic req = 1'b0, req_wr = 1'b0, mux = 1'b1, busy, done, wstb, arr_wr, arr_rd, arr_fetch;
  logic [15:0] req_addr = 16'h0000, arr_addr;
  logic [7:0] req_wdata = 8'h00, rd_lo = 8'h00, rd_up = 8'h00, rdata, wd_lo, wd_up;
  logic [1:0] mode = 2'h0;
  logic [3:0] sel = 4'h0;
  logic wstb_seen = 1'b0, drv_seen = 1'b0, rd_seen = 1'b0;
  int mismatches = 0, tests_run = 0, cycles = 0;
  mbf_bus_if bus ();
  mbf_host i_mbf_host (.MCLK_I(MCLK_I), .RSTN_I(RSTN_I), .BUS(bus.host), .REQ_I(req), .REQ_WR_I(req_wr),
    .REQ_ADDR_I(req_addr), .REQ_WDATA_I(req_wdata), .MUX_I(mux), .BUSY_O(busy), .DONE_O(done), .RDATA_O(rdata));
  mbf_device i_mbf_device (.MCLK_I(MCLK_I), .RSTN_I(RSTN_I), .BUS(bus.dev), .BUS_MODE_I(mode),
    .WR_STYLE_I(MBF_WR_STROBE), .RD_STYLE_I(MBF_RD_STROBE), .AS_ACTIVE_HIGH_I(1'b1), .BLOCK_SEL_I(sel),
    .RD_LO_I(rd_lo), .RD_UP_I(rd_up), .ARRAY_ADDR_O(arr_addr), .ARRAY_WR_O(arr_wr), .ARRAY_RD_O(arr_rd),
    .ARRAY_FETCH_O(arr_fetch), .WDATA_LO_O(wd_lo), .WDATA_UP_O(wd_up), .WRITE_STB_O(wstb));
  mbf_bus_monitor i_mbf_bus_monitor (.MCLK_I(MCLK_I), .RSTN_I(RSTN_I), .lo_h_oe_n(bus.lo_h_oe_n),
    .lo_d_oe_n(bus.lo_d_oe_n), .up_d_oe_n(bus.up_d_oe_n), .address_strobe(bus.address_strobe),
    .write_control_input(bus.write_control_input), .read_control_input(bus.read_control_input));
  initial forever #5 MCLK_I = ~MCLK_I;
  // ----------------------------------------
  // sticky flags and hang guard
  // ----------------------------------------
  always @(posedge MCLK_I) begin
    if (wstb) wstb_seen <= 1'b1;
    if (arr_rd) rd_seen <= 1'b1;
    if (bus.lo_d_oe_n === 1'b0) drv_seen <= 1'b1;
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one host transfer; gap after done lets the device release the port
  task automatic op(input logic wr, input logic [15:0] a, input logic [7:0] d);
    int n = 0;
    @(posedge MCLK_I) #1;
    {wstb_seen, drv_seen, rd_seen} = 3'h0;
    req = 1'b1;
    req_wr = wr;
    req_addr = a;
    req_wdata = d;
    @(posedge MCLK_I) #1;
    req = 1'b0;
    while (done !== 1'b1 && n < 40) begin
      @(posedge MCLK_I) #1;
      n++;
    end
    check("done", {15'h0000, done}, 16'h0001);
    repeat (5) @(posedge MCLK_I);
    #1;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge MCLK_I);
    #1;
    RSTN_I = 1'b1;
    for (int m = 0; m < 2; m++) begin
      mode = 2'(m);
      mux = (m == 0);
      op(1'b1, 16'hA5C3 ^ 16'(m), 8'h5A);
      check("addr", arr_addr, 16'hA5C3 ^ 16'(m));
      check("wdata", {8'h00, wd_lo}, 16'h005A);
      check("wstb", {15'h0000, wstb_seen}, 16'h0001);
      check("wdata up", {8'h00, wd_up}, 16'h0000);
      check("array wr", {15'h0000, arr_wr}, 16'h0000);
      check("fetch", {15'h0000, arr_fetch}, 16'h0000);
      rd_lo = 8'h3C;
      sel = 4'h8;
      op(1'b0, 16'h1E0F, 8'h00);
      check("rdata", {8'h00, rdata}, 16'h003C);
      check("drive", {15'h0000, drv_seen}, 16'h0001);
      check("array rd", {15'h0000, rd_seen}, 16'h0001);
      check("addr", arr_addr, 16'h1E0F);
      sel = 4'h0;
      op(1'b0, 16'hF00D, 8'h00);
      check("quiet", {15'h0000, drv_seen}, 16'h0000);
      check("addr", arr_addr, 16'hF00D);
      $display("test mode %0d ended", m);
    end
    complete_run();
  end
endmodule // mcu_bus_front_end_tb
